// ===== core/uitp_pkg.sv
// Package: register indices, field positions and reset values of the shared control logic
package uitp_pkg;
  // Register indices on the parallel bus
  localparam logic [3:0] UITP_REG_AUX_CONTROL    = 4'h0;
  localparam logic [3:0] UITP_REG_IRQ_STATUS     = 4'h1;
  localparam logic [3:0] UITP_REG_IRQ_MASK       = 4'h2;
  localparam logic [3:0] UITP_REG_PRELOAD_HI     = 4'h3;
  localparam logic [3:0] UITP_REG_PRELOAD_LO     = 4'h4;
  localparam logic [3:0] UITP_REG_COUNT_HI       = 4'h5;
  localparam logic [3:0] UITP_REG_COUNT_LO       = 4'h6;
  localparam logic [3:0] UITP_REG_SCRATCH        = 4'h7;
  localparam logic [3:0] UITP_REG_INPUT_LEVEL    = 4'h8;
  localparam logic [3:0] UITP_REG_OUTPORT_CONFIG = 4'h9;
  localparam logic [3:0] UITP_REG_START          = 4'hA;
  localparam logic [3:0] UITP_REG_STOP           = 4'hB;
  localparam logic [3:0] UITP_REG_INPUT_CHANGE   = 4'hC;
  localparam logic [3:0] UITP_REG_OUTPORT_SET    = 4'hD;
  localparam logic [3:0] UITP_REG_OUTPORT_CLEAR  = 4'hE;
  // Host-side AHB registers (byte offsets)
  localparam logic [7:0] UITP_AHB_CMD            = 8'h00;
  localparam logic [7:0] UITP_AHB_STATUS         = 8'h04;
  localparam logic [7:0] UITP_AHB_RDATA          = 8'h08;
  // Host command word fields
  localparam int         UITP_CMD_WRITE_BIT      = 8;
  localparam int         UITP_CMD_ADDR_LSB       = 12;
  // Field positions
  localparam int         UITP_AUX_MODE_LSB       = 4;
  localparam int         UITP_AUX_TIMER_BIT      = 6;
  localparam int         UITP_AUX_TABLE_BIT      = 7;
  localparam int         UITP_ISR_CT_BIT         = 3;
  localparam int         UITP_ISR_IPC_BIT        = 7;
  // Reset values and the prescaler's last count
  localparam logic [7:0] UITP_RESET_BYTE         = 8'h00;
  localparam logic [7:0] UITP_RESET_OUTPORT      = 8'hFF;
  localparam logic [3:0] UITP_PRESCALE_LAST      = 4'hF;
endpackage

// ===== core/uitp_bus_if.sv
// Interface: parallel register bus between host end and device end
`timescale 1ns/1ps
interface uitp_bus_if;
  logic [3:0] addr;
  logic       rd_stb;
  logic       wr_stb;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       irq_n;
  modport device (input addr, input rd_stb, input wr_stb, input wdata, output rdata, output irq_n);
  modport host   (output addr, output rd_stb, output wr_stb, output wdata, input rdata, input irq_n);
endinterface

// ===== core/uitp_device.sv
// Device end: interrupt status and mask, counter/timer, input level, output function multiplexer
`timescale 1ns/1ps
module uitp_device (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // Register bus
  uitp_bus_if.device      bus,
  // Inputs and channel status
  input  wire logic [6:0] inputs_in,
  input  wire logic       xtal_in,
  input  wire logic       chan_a_tx_bit_clk_in,
  input  wire logic       chan_b_tx_bit_clk_in,
  input  wire logic       chan_a_tx_clk16_in,
  input  wire logic       chan_a_rx_bit_clk_in,
  input  wire logic       chan_b_rx_bit_clk_in,
  input  wire logic [1:0] tx_trigger_met_in,
  input  wire logic [1:0] rx_trigger_met_in,
  input  wire logic [1:0] break_change_in,
  input  wire logic [3:0] chan_a_command_in,
  input  wire logic [3:0] chan_b_command_in,
  input  wire logic       command_stb_in,
  // Outputs
  output logic [7:2]      outport_out,
  output logic            baud_table_out
);
  import uitp_pkg::*;
  logic [7:0]  aux_q, mask_q, pre_hi_q, pre_lo_q, scratch_q, outport_config_q, opreg_q, status_q;
  logic [15:0] count_q;
  logic        running_q, ct_out_q, ct_out_d, sq_q;
  logic [3:0]  presc_q;
  logic [3:0]  in_prev_q;
  logic [3:0]  change_q;
  logic        src_q, src_prev_q, src_d, tick;
  logic [7:0]  rdata_q;
  logic        irq_n_q;
  logic        is_timer;
  logic        rd_start, rd_stop, rd_change, expire;
  logic [3:0]  in_change;
  logic [7:0]  ready_bits;
  logic [7:0]  out_d;

  assign is_timer  = aux_q[UITP_AUX_TIMER_BIT];
  assign rd_start  = bus.rd_stb && (bus.addr == UITP_REG_START);
  assign rd_stop   = bus.rd_stb && (bus.addr == UITP_REG_STOP);
  assign rd_change = bus.rd_stb && (bus.addr == UITP_REG_INPUT_CHANGE);
  assign in_change = inputs_in[3:0] ^ in_prev_q;
  assign expire    = tick && (count_q == 16'h0000);

  // ==========================================================
  // Register writes
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      aux_q     <= UITP_RESET_BYTE;
      mask_q    <= UITP_RESET_BYTE;
      pre_hi_q  <= UITP_RESET_BYTE;
      pre_lo_q  <= UITP_RESET_BYTE;
      scratch_q <= UITP_RESET_BYTE;
      outport_config_q    <= UITP_RESET_BYTE;
    end else if (bus.wr_stb) begin
      if (bus.addr == UITP_REG_AUX_CONTROL) begin
        aux_q <= bus.wdata;
      end else if (bus.addr == UITP_REG_IRQ_MASK) begin
        mask_q <= bus.wdata;
      end else if (bus.addr == UITP_REG_PRELOAD_HI) begin
        pre_hi_q <= bus.wdata;
      end else if (bus.addr == UITP_REG_PRELOAD_LO) begin
        pre_lo_q <= bus.wdata;
      end else if (bus.addr == UITP_REG_SCRATCH) begin
        scratch_q <= bus.wdata;
      end else if (bus.addr == UITP_REG_OUTPORT_CONFIG) begin
        outport_config_q <= bus.wdata;
      end
    end
  end

  // Baud table select is only forwarded; the channels own its use
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      baud_table_out <= 1'b0;
    end else begin
      baud_table_out <= aux_q[UITP_AUX_TABLE_BIT];
    end
  end

  // ==========================================================
  // Clock source select: sources are sampled and a rising edge is one tick, except under the divide-by-16 codes
  always_comb begin
    case (aux_q[UITP_AUX_MODE_LSB +: 3])
      3'h0:    src_d = inputs_in[2];
      3'h1:    src_d = chan_a_tx_bit_clk_in;
      3'h2:    src_d = chan_b_tx_bit_clk_in;
      3'h3:    src_d = xtal_in;
      3'h4:    src_d = inputs_in[2];
      3'h5:    src_d = inputs_in[2];
      default: src_d = xtal_in;
    endcase
  end

  // Divide-by-16 codes 011, 101, 111 count sixteen rising edges per tick
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      src_q      <= 1'b0;
      src_prev_q <= 1'b0;
      presc_q    <= 4'h0;
      tick       <= 1'b0;
    end else begin
      src_q      <= src_d;
      src_prev_q <= src_q;
      tick       <= 1'b0;
      if (src_q && !src_prev_q) begin
        if (aux_q[UITP_AUX_MODE_LSB] && (aux_q[UITP_AUX_MODE_LSB +: 3] != 3'h1)) begin
          presc_q <= presc_q + 4'h1;
          tick    <= (presc_q == UITP_PRESCALE_LAST);
        end else begin
          tick <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Counter / timer core
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      running_q <= 1'b0;
      count_q   <= 16'h0000;
      ct_out_q  <= 1'b1;
      sq_q      <= 1'b0;
    end else if (is_timer) begin
      // Timer free-runs once started; stop reads do not halt it
      if (rd_start) begin
        running_q <= 1'b1;
        count_q   <= {pre_hi_q, pre_lo_q};
      end else if (running_q && tick) begin
        if (count_q <= 16'h0001) begin
          count_q <= {pre_hi_q, pre_lo_q};
          sq_q    <= ~sq_q;
        end else begin
          count_q <= count_q - 16'h0001;
        end
      end
      ct_out_q <= sq_q;
    end else begin
      if (rd_start && !running_q) begin
        running_q <= 1'b1;
        count_q   <= {pre_hi_q, pre_lo_q};
      end else if (rd_stop) begin
        running_q <= 1'b0;
        ct_out_q  <= 1'b1;
      end else if (running_q && tick) begin
        count_q <= count_q - 16'h0001;
        if (count_q == 16'h0001) begin
          ct_out_q <= 1'b0;
        end
      end
    end
  end

  assign ct_out_d = is_timer && !ct_out_q && sq_q;

  // ==========================================================
  // Interrupt status
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      in_prev_q <= 4'h0;
      change_q  <= 4'h0;
    end else begin
      in_prev_q <= inputs_in[3:0];
      change_q  <= (rd_change ? 4'h0 : change_q) | in_change;
    end
  end

  // Sets are applied after clears so a coincident event survives, except a counter expiry on a stop read
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      status_q <= UITP_RESET_BYTE;
    end else begin
      status_q[0] <= tx_trigger_met_in[0];
      status_q[4] <= tx_trigger_met_in[1];
      status_q[1] <= rx_trigger_met_in[0];
      status_q[5] <= rx_trigger_met_in[1];
      status_q[2] <= (status_q[2] && !(command_stb_in && chan_a_command_in == 4'h5)) || break_change_in[0];
      status_q[6] <= (status_q[6] && !(command_stb_in && chan_b_command_in == 4'h5)) || break_change_in[1];
      status_q[UITP_ISR_CT_BIT] <= (status_q[UITP_ISR_CT_BIT] && !rd_stop) || ct_out_d
                                   || (!is_timer && running_q && tick && count_q == 16'h0001 && !rd_stop);
      status_q[UITP_ISR_IPC_BIT] <= (status_q[UITP_ISR_IPC_BIT] && !rd_change)
                                    || |(in_change & aux_q[3:0]);
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      irq_n_q <= 1'b1;
    end else begin
      irq_n_q <= ~|(status_q & mask_q);
    end
  end
  assign bus.irq_n = irq_n_q;

  // ==========================================================
  // Read data
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_q <= UITP_RESET_BYTE;
    end else if (bus.rd_stb) begin
      if (bus.addr == UITP_REG_AUX_CONTROL) begin
        rdata_q <= aux_q;
      end else if (bus.addr == UITP_REG_IRQ_STATUS) begin
        rdata_q <= status_q;
      end else if (bus.addr == UITP_REG_IRQ_MASK) begin
        rdata_q <= mask_q;
      end else if (bus.addr == UITP_REG_PRELOAD_HI) begin
        rdata_q <= pre_hi_q;
      end else if (bus.addr == UITP_REG_PRELOAD_LO) begin
        rdata_q <= pre_lo_q;
      end else if (bus.addr == UITP_REG_COUNT_HI) begin
        rdata_q <= count_q[15:8];
      end else if (bus.addr == UITP_REG_COUNT_LO) begin
        rdata_q <= count_q[7:0];
      end else if (bus.addr == UITP_REG_SCRATCH) begin
        rdata_q <= scratch_q;
      end else if (bus.addr == UITP_REG_INPUT_LEVEL) begin
        rdata_q <= {1'b0, inputs_in};
      end else if (bus.addr == UITP_REG_INPUT_CHANGE) begin
        rdata_q <= {change_q, inputs_in[3:0]};
      end else begin
        rdata_q <= UITP_RESET_BYTE;
      end
    end
  end
  assign bus.rdata = rdata_q;

  // ==========================================================
  // Output port: set drives low, clear drives high
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      opreg_q <= UITP_RESET_OUTPORT;
    end else if (bus.wr_stb && bus.addr == UITP_REG_OUTPORT_SET) begin
      opreg_q <= opreg_q & ~bus.wdata;
    end else if (bus.wr_stb && bus.addr == UITP_REG_OUTPORT_CLEAR) begin
      opreg_q <= opreg_q | bus.wdata;
    end
  end

  assign ready_bits = {~status_q[4], ~status_q[0], ~status_q[5], ~status_q[1], 4'h0};

  always_comb begin
    out_d = opreg_q;
    case (outport_config_q[1:0])
      2'h1:    out_d[2] = chan_a_tx_clk16_in;
      2'h2:    out_d[2] = chan_a_tx_bit_clk_in;
      2'h3:    out_d[2] = chan_a_rx_bit_clk_in;
      default: out_d[2] = opreg_q[2];
    endcase
    case (outport_config_q[3:2])
      2'h1:    out_d[3] = ct_out_q;
      2'h2:    out_d[3] = chan_b_tx_bit_clk_in;
      2'h3:    out_d[3] = chan_b_rx_bit_clk_in;
      default: out_d[3] = opreg_q[3];
    endcase
  end

  // Ready outputs take status, never the mask
  genvar g;
  for (g = 4; g < 8; g++) begin : g_rdy
    always_ff @(posedge clk_in) begin
      if (rst_in) begin
        outport_out[g] <= 1'b1;
      end else begin
        outport_out[g] <= outport_config_q[g] ? ready_bits[g] : opreg_q[g];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      outport_out[3:2] <= 2'h3;
    end else begin
      outport_out[3:2] <= out_d[3:2];
    end
  end
endmodule

// ===== core/uitp_host.sv
// Host end: AHB-Lite slave that turns software commands into register bus cycles
`timescale 1ns/1ps
module uitp_host (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // AHB-Lite slave
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic [31:0]      hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  // Register bus
  uitp_bus_if.host         bus
);
  import uitp_pkg::*;
  typedef enum logic [3:0] {
    UITP_IDLE = 4'b0001,
    UITP_STRB = 4'b0010,
    UITP_WAIT = 4'b0100,
    UITP_CAPT = 4'b1000
  } uitp_state_t;
  uitp_state_t state_q;
  logic        ph_wr_q, ph_rd_q;
  logic [7:0]  ph_addr_q;
  logic [3:0]  addr_q;
  logic [7:0]  wdata_q, rdata_q;
  logic        wr_q, rd_q, cmd_wr_q, busy_q;

  // ==========================================================
  // AHB address phase capture
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ph_wr_q   <= 1'b0;
      ph_rd_q   <= 1'b0;
      ph_addr_q <= 8'h00;
    end else if (hready_in) begin
      ph_wr_q   <= hsel_in && htrans_in[1] && hwrite_in;
      ph_rd_q   <= hsel_in && htrans_in[1] && !hwrite_in;
      ph_addr_q <= haddr_in[7:0];
    end
  end

  // ==========================================================
  // Command issue: one strobe cycle, one cycle for the device answer, then capture
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_q  <= UITP_IDLE;
      addr_q   <= 4'h0;
      wdata_q  <= 8'h00;
      wr_q     <= 1'b0;
      rd_q     <= 1'b0;
      cmd_wr_q <= 1'b0;
      busy_q   <= 1'b0;
      rdata_q  <= 8'h00;
    end else begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      case (state_q)
        UITP_IDLE: begin
          // Commands while busy are dropped; software polls status first
          if (ph_wr_q && ph_addr_q == UITP_AHB_CMD) begin
            addr_q   <= hwdata_in[UITP_CMD_ADDR_LSB +: 4];
            wdata_q  <= hwdata_in[7:0];
            cmd_wr_q <= hwdata_in[UITP_CMD_WRITE_BIT];
            busy_q   <= 1'b1;
            state_q  <= UITP_STRB;
          end
        end
        UITP_STRB: begin
          wr_q    <= cmd_wr_q;
          rd_q    <= !cmd_wr_q;
          state_q <= UITP_WAIT;
        end
        UITP_WAIT: begin
          // Device read data only stands from the cycle after the strobe is taken
          state_q <= UITP_CAPT;
        end
        UITP_CAPT: begin
          if (!cmd_wr_q) begin
            rdata_q <= bus.rdata;
          end
          busy_q  <= 1'b0;
          state_q <= UITP_IDLE;
        end
        default: state_q <= UITP_IDLE;
      endcase
    end
  end

  assign bus.addr   = addr_q;
  assign bus.wdata  = wdata_q;
  assign bus.wr_stb = wr_q;
  assign bus.rd_stb = rd_q;

  // ==========================================================
  // AHB read data: zero-wait, always OKAY
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      hrdata_out <= 32'h0000_0000;
    end else if (hready_in && hsel_in && htrans_in[1] && !hwrite_in) begin
      if (haddr_in[7:0] == UITP_AHB_STATUS) begin
        hrdata_out <= {30'h0, ~bus.irq_n, busy_q};
      end else if (haddr_in[7:0] == UITP_AHB_RDATA) begin
        hrdata_out <= {24'h0, rdata_q};
      end else begin
        hrdata_out <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
    end else begin
      hreadyout_out <= 1'b1;
      hresp_out     <= 1'b0;
    end
  end
endmodule

// ===== sim/uitp_bus_chk.sv
// Checker: timing and register relations on the bus between the host end and the device end
`timescale 1ns/1ps
module uitp_bus_chk
  import uitp_pkg::*;
(
  // Clock and reset
  input wire logic       clk_in,
  input wire logic       rst_in,
  // Bus signals
  input wire logic [3:0] addr,
  input wire logic       rd_stb,
  input wire logic       wr_stb,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic       irq_n
);
  logic [7:0] scratch_q;
  logic [7:0] mask_q;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // ==========================================
  // Shadow copies of written registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      scratch_q <= UITP_RESET_BYTE;
    end else if (wr_stb && addr == UITP_REG_SCRATCH) begin
      scratch_q <= wdata;
    end
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mask_q <= UITP_RESET_BYTE;
    end else if (wr_stb && addr == UITP_REG_IRQ_MASK) begin
      mask_q <= wdata;
    end
  end

  // ==========================================
  // Assertions
  a_strobe_excl: assert property (!(rd_stb && wr_stb)) else $error("read and write strobes together");
  a_read_pulse: assert property (rd_stb |=> !rd_stb) else $error("read strobe longer than one cycle");
  a_rdata_hold: assert property (!rd_stb |=> $stable(rdata)) else $error("read data moved without a read");
  a_scratch_echo: assert property (rd_stb && addr == UITP_REG_SCRATCH |=> rdata == scratch_q)
    else $error("scratch byte read differs from last write");
  a_level_msb: assert property (rd_stb && addr == UITP_REG_INPUT_LEVEL |=> rdata[7] == 1'b0)
    else $error("input level top bit not zero");
  a_unmapped_zero: assert property (rd_stb && addr == 4'hF |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  // Two quiet cycles of the mask cover the one-cycle lag of the pin
  a_mask_closed: assert property (mask_q == 8'h00 && $past(mask_q) == 8'h00 |-> irq_n)
    else $error("interrupt pin low with mask clear");
  a_irq_combine: assert property (rd_stb && addr == UITP_REG_IRQ_STATUS |=>
    irq_n == !(|(rdata & $past(mask_q)))) else $error("interrupt pin not inverted masked status");
  a_reset_quiet: assert property (@(posedge clk_in) disable iff (1'b0) rst_in |=> irq_n && rdata == 8'h00)
    else $error("pin or read data not idle after reset");
endmodule

// ===== sim/tb_uart_irq_timer_port_logic.sv
// Testbench: AHB commands through both ends, checking status, mask, counter/timer and output pins
`timescale 1ns/1ps
module tb_uart_irq_timer_port_logic;
  import uitp_pkg::*;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        hsel   = 1'b0;
  logic [31:0] haddr  = 32'h0;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic [6:0]  inp    = 7'h00;
  logic [6:0]  sv     = 7'h00;
  logic [1:0]  txm    = 2'b00;
  logic [1:0]  rxm    = 2'b00;
  logic [1:0]  brk    = 2'b00;
  logic [3:0]  cmd_a  = 4'h0;
  logic [3:0]  cmd_b  = 4'h0;
  logic        cstb   = 1'b0;
  logic [7:2]  opins;
  logic        baud;
  logic [7:0]  r;
  logic [7:0]  e;
  int          errors = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          dv;
  int          sb[4]  = '{0, 1, 4, 5};
  int          pn[4]  = '{4, 2, 5, 3};
  int          src[8] = '{6, 1, 3, 5, 6, 6, 5, 5};

  always #5 clk_in = ~clk_in;

  uitp_bus_if uitp_bus_if_i ();
  uitp_host uitp_host_i (.clk_in(clk_in), .rst_in(rst_in), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(3'b010), .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
    .hreadyout_out(hready), .hresp_out(hresp), .bus(uitp_bus_if_i.host));
  // sv[6] is ORed onto multi_in_2 so the clock sources share one tick task
  uitp_device uitp_device_i (.clk_in(clk_in), .rst_in(rst_in), .bus(uitp_bus_if_i.device),
    .inputs_in({inp[6:3], inp[2] | sv[6], inp[1:0]}), .xtal_in(sv[5]), .chan_a_tx_bit_clk_in(sv[1]),
    .chan_b_tx_bit_clk_in(sv[3]), .chan_a_tx_clk16_in(sv[0]), .chan_a_rx_bit_clk_in(sv[2]),
    .chan_b_rx_bit_clk_in(sv[4]), .tx_trigger_met_in(txm), .rx_trigger_met_in(rxm), .break_change_in(brk),
    .chan_a_command_in(cmd_a), .chan_b_command_in(cmd_b), .command_stb_in(cstb), .outport_out(opins),
    .baud_table_out(baud));
  uitp_bus_chk uitp_bus_chk_i (.clk_in(clk_in), .rst_in(rst_in), .addr(uitp_bus_if_i.addr),
    .rd_stb(uitp_bus_if_i.rd_stb), .wr_stb(uitp_bus_if_i.wr_stb), .wdata(uitp_bus_if_i.wdata),
    .rdata(uitp_bus_if_i.rdata), .irq_n(uitp_bus_if_i.irq_n));

  // ==========================================
  // Tasks
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    logic ok;
    @(posedge clk_in);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    do begin @(negedge clk_in); ok = hready; @(posedge clk_in); end while (ok !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do begin @(negedge clk_in); ok = hready; rd = hrdata; @(posedge clk_in); end while (ok !== 1'b1);
  endtask
  // Polls busy before and after, since a command sent while busy is dropped
  task automatic dev(input logic w, input logic [3:0] i, input logic [7:0] d);
    logic [31:0] s;
    do ahb(1'b0, UITP_AHB_STATUS, 32'h0, s); while (s[0] !== 1'b0);
    ahb(1'b1, UITP_AHB_CMD, {16'h0, i, 3'b000, w, d}, s);
    do ahb(1'b0, UITP_AHB_STATUS, 32'h0, s); while (s[0] !== 1'b0);
    ahb(1'b0, UITP_AHB_RDATA, 32'h0, s);
    r = s[7:0];
  endtask
  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    dev(1'b1, i, d);
  endtask
  task automatic rd(input logic [3:0] i);
    dev(1'b0, i, 8'h00);
  endtask
  task automatic settle;
    repeat (4) @(posedge clk_in);
  endtask
  task automatic tick(input int b, input int n);
    repeat (n) begin
      @(posedge clk_in);
      sv[b] <= 1'b1;
      repeat (3) @(posedge clk_in);
      sv[b] <= 1'b0;
      repeat (2) @(posedge clk_in);
    end
  endtask

  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      $display("[ERR] %0t run did not finish in time", $time);
      give_verdict();
    end
  end

  // ==========================================
  // Main sequence
  initial begin
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(UITP_REG_IRQ_MASK); chk(r, 8'h00);
    rd(UITP_REG_IRQ_STATUS); chk(r, 8'h00);
    chk({7'h0, uitp_bus_if_i.irq_n}, 8'h01);
    chk({2'b0, opins}, 8'h3F);
    inp <= 7'h7B;
    settle();
    rd(UITP_REG_INPUT_LEVEL); chk(r, 8'h7B);
    rd(4'hF); chk(r, 8'h00);
    chk({7'h0, hresp}, 8'h00);
    wr(UITP_REG_SCRATCH, 8'hA5);
    rd(UITP_REG_SCRATCH); chk(r, 8'hA5);
    wr(UITP_REG_AUX_CONTROL, 8'h80); chk({7'h0, baud}, 8'h01);
    wr(UITP_REG_AUX_CONTROL, 8'h00); chk({7'h0, baud}, 8'h00);
    $display("test reset_and_registers done");

    wr(UITP_REG_OUTPORT_CONFIG, 8'hF0);
    for (int k = 0; k < 4; k++) begin
      txm <= {k == 2, k == 0};
      rxm <= {k == 3, k == 1};
      settle();
      rd(UITP_REG_IRQ_STATUS); chk(r, 8'h01 << sb[k]);
      e = 8'h3F & ~(8'h01 << pn[k]);
      chk({2'b0, opins}, e);
      chk({7'h0, uitp_bus_if_i.irq_n}, 8'h01);
    end
    wr(UITP_REG_IRQ_MASK, 8'hDF); chk({7'h0, uitp_bus_if_i.irq_n}, 8'h01);
    wr(UITP_REG_IRQ_MASK, 8'h20); chk({7'h0, uitp_bus_if_i.irq_n}, 8'h00);
    rd(UITP_REG_IRQ_STATUS); chk(r, 8'h20);
    rxm <= 2'b00;
    settle();
    chk({7'h0, uitp_bus_if_i.irq_n}, 8'h01);
    wr(UITP_REG_OUTPORT_CONFIG, 8'h00);
    wr(UITP_REG_OUTPORT_SET, 8'h80); chk({2'b0, opins}, 8'h1F);
    wr(UITP_REG_OUTPORT_CLEAR, 8'h80); chk({2'b0, opins}, 8'h3F);
    $display("test ready_mask_pins done");

    for (int ch = 0; ch < 2; ch++) begin
      e = ch ? 8'h40 : 8'h04;
      @(posedge clk_in) brk[ch] <= 1'b1;
      @(posedge clk_in) brk[ch] <= 1'b0;
      settle();
      rd(UITP_REG_IRQ_STATUS); chk(r, e);
      for (int c = 4; c < 6; c++) begin
        @(posedge clk_in);
        cmd_a <= ch ? 4'h0 : c[3:0];
        cmd_b <= ch ? c[3:0] : 4'h0;
        cstb <= 1'b1;
        @(posedge clk_in) cstb <= 1'b0;
        settle();
        rd(UITP_REG_IRQ_STATUS); chk(r, c == 4 ? e : 8'h00);
      end
    end
    wr(UITP_REG_AUX_CONTROL, 8'h01);
    inp[1] <= 1'b0;
    settle();
    rd(UITP_REG_IRQ_STATUS); chk(r, 8'h00);
    inp[0] <= 1'b0;
    settle();
    rd(UITP_REG_IRQ_STATUS); chk(r, 8'h80);
    rd(UITP_REG_INPUT_CHANGE); chk(r, 8'hB8);
    rd(UITP_REG_IRQ_STATUS); chk(r, 8'h00);
    $display("test break_and_input_change done");

    wr(UITP_REG_IRQ_MASK, 8'h00);
    wr(UITP_REG_OUTPORT_CONFIG, 8'h04);
    wr(UITP_REG_PRELOAD_HI, 8'h00);
    for (int c = 0; c < 8; c++) begin
      dv = (c == 3 || c == 5 || c == 7) ? 16 : 1;
      rd(UITP_REG_STOP);
      // Output 3 is released and the timer source stays masked while the mode field moves
      wr(UITP_REG_OUTPORT_CONFIG, 8'h00);
      wr(UITP_REG_AUX_CONTROL, 8'(c << 4));
      wr(UITP_REG_PRELOAD_LO, c < 4 ? 8'h02 : 8'h01);
      rd(UITP_REG_START);
      wr(UITP_REG_OUTPORT_CONFIG, 8'h04);
      if (c < 4) begin
        // A preload written while running must wait for the next start
        wr(UITP_REG_PRELOAD_LO, 8'h09);
        tick(src[c], dv);
        rd(UITP_REG_IRQ_STATUS); chk(r, 8'h00);
        tick(src[c], dv);
        rd(UITP_REG_IRQ_STATUS); chk(r, 8'h08);
        chk({7'h0, opins[3]}, 8'h00);
        rd(UITP_REG_STOP);
        rd(UITP_REG_IRQ_STATUS); chk(r, 8'h00);
        chk({7'h0, opins[3]}, 8'h01);
        rd(UITP_REG_COUNT_LO); chk(r, 8'h00);
        rd(UITP_REG_COUNT_HI); chk(r, 8'h00);
      end else begin
        tick(src[c], 4 * dv);
        rd(UITP_REG_IRQ_STATUS); chk(r, 8'h08);
        rd(UITP_REG_STOP);
        rd(UITP_REG_IRQ_STATUS); chk(r, 8'h00);
        tick(src[c], 4 * dv);
        rd(UITP_REG_IRQ_STATUS); chk(r, 8'h08);
      end
    end
    rd(UITP_REG_STOP);
    $display("test counter_timer_codes done");

    @(posedge clk_in) brk[0] <= 1'b1;
    @(posedge clk_in) brk[0] <= 1'b0;
    wr(UITP_REG_IRQ_MASK, 8'h04); chk({7'h0, uitp_bus_if_i.irq_n}, 8'h00);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(UITP_REG_IRQ_STATUS); chk(r, 8'h00);
    rd(UITP_REG_IRQ_MASK); chk(r, 8'h00);
    chk({7'h0, uitp_bus_if_i.irq_n}, 8'h01);
    $display("test second_reset done");
    give_verdict();
  end
endmodule
